// file: common/sgm_pkg.sv
/*
  Constants, field layout, source codes and reset values of the signal
  modulator: register indices, bit positions and the enum
  for the carrier phase.
  Assumes an 8-bit register port with a 2-bit word index and one clock.
*/
// Contract
// RULE_01: Output mixes modulator with high or low carrier
// RULE_02: Disabled forces carriers ground, modulator software bit
// RULE_03: Pin enable cleared drives output pin low
// RULE_04: Enable bit starts mixing; cleared gives no output
// RULE_05: Pin enable bit gates output onto pin
// RULE_06: High sync waits high carrier fall before switching
// RULE_07: Low sync waits low carrier fall before switching
// RULE_08: No sync switches carriers immediately, independently
// RULE_09: High carrier invert bit inverts high carrier
// RULE_10: Low carrier invert bit inverts low carrier
// RULE_11: High carrier pin disable blocks its peripheral pin
// RULE_12: Low carrier pin disable blocks its peripheral pin
// RULE_13: Modulator source pin disable blocks its pin
// RULE_14: Modulator source field code map
// RULE_15: Carrier select field code map, rest reserved
// RULE_16: Software bit used only when selected
// RULE_17: Output invert bit inverts pin output
// RULE_18: Slew limit bit resets one, clear removes it
// RULE_19: Status bit reads back current modulator output
// RULE_20: Keeps operating in sleep while sources run
// RULE_21: Reset disables modulator, registers take defaults
// RULE_22: Unimplemented bits ignore writes, read zero
package sgm_pkg;

  // Register port geometry
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int SEL_W  = 4;
  localparam int NUM_PWM = 5;

  // Register word indices
  localparam logic [ADDR_W-1:0] REG_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] REG_SRC  = 2'h1;
  localparam logic [ADDR_W-1:0] REG_HCAR = 2'h2;
  localparam logic [ADDR_W-1:0] REG_LCAR = 2'h3;

  // modulation_control bit positions
  localparam int CTRL_EN_BIT    = 7;
  localparam int CTRL_OE_BIT    = 6;
  localparam int CTRL_SLEW_BIT  = 5;
  localparam int CTRL_OINV_BIT  = 4;
  localparam int CTRL_STAT_BIT  = 3;
  localparam int CTRL_SWBIT_BIT = 0;

  // modulation_source_select and carrier control bit positions
  localparam int SRC_DIS_BIT  = 7;
  localparam int CAR_DIS_BIT  = 7;
  localparam int CAR_INV_BIT  = 6;
  localparam int CAR_SYNC_BIT = 5;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h20;
  localparam logic [DATA_W-1:0] SRC_RST  = 8'h00;
  localparam logic [DATA_W-1:0] CAR_RST  = 8'h00;

  // Modulator source codes
  localparam logic [SEL_W-1:0] MOD_SW   = 4'h0;
  localparam logic [SEL_W-1:0] MOD_PIN  = 4'h1;
  localparam logic [SEL_W-1:0] MOD_SDO  = 4'h2;
  localparam logic [SEL_W-1:0] MOD_TX1  = 4'h3;
  localparam logic [SEL_W-1:0] MOD_TX2  = 4'h4;
  localparam logic [SEL_W-1:0] MOD_PWM1 = 4'h5;

  // Carrier source codes
  localparam logic [SEL_W-1:0] CAR_GND    = 4'h0;
  localparam logic [SEL_W-1:0] CAR_PIN1   = 4'h1;
  localparam logic [SEL_W-1:0] CAR_PIN2   = 4'h2;
  localparam logic [SEL_W-1:0] CAR_REFCLK = 4'h3;
  localparam logic [SEL_W-1:0] CAR_PWM1   = 4'h4;

  // Which carrier is being mixed
  typedef enum logic {
    PHASE_LOW,
    PHASE_HIGH
  } sgm_phase_e;

endpackage

// file: hw/sgm_sync2.sv
/*
  Two-flop synchroniser for the four asynchronous inputs of the modulator.
  Assumes inputs change freely relative to core_clk; outputs lag two edges.
*/
`timescale 1ns/1ps
`default_nettype none
module sgm_sync2 (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Raw and synchronised levels
  input  wire logic [3:0] async_in,
  output logic      [3:0] sync_out
);

  typedef struct packed {
    logic [3:0] stage1;
    logic [3:0] stage2;
  } sgm_sync_s;

  sgm_sync_s q;
  sgm_sync_s d;

  // First stage only feeds the second, to contain metastability
  always_comb begin
    d        = q;
    d.stage1 = async_in;
    d.stage2 = q.stage1;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stage2;

endmodule // sgm_sync2
`default_nettype wire

// file: hw/sgm_signal_modulator.sv
/*
  Signal modulator: picks a modulator source and two carriers, mixes them,
  and drives the modulated output pin, the slew-limit control and the pin
  disables of the source peripherals. Four 8-bit registers on a plain port.
  Assumes peripheral signals are on core_clk and pin/refclock inputs are not.
*/
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sgm_signal_modulator (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  // Register port
  input  wire logic [sgm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [sgm_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [sgm_pkg::DATA_W-1:0] reg_rdata,
  // Asynchronous sources
  input  wire logic                       modulator_input_pin,
  input  wire logic                       carrier_input_pin_one,
  input  wire logic                       carrier_input_pin_two,
  input  wire logic                       ref_clk_in,
  // On-chip peripheral sources
  input  wire logic [sgm_pkg::NUM_PWM-1:0] pwm_out,
  input  wire logic                       sdo_out,
  input  wire logic [1:0]                 tx_out,
  // Modulated output
  output logic                            modulated_output_pin,
  output logic                            output_slew_limit,
  // Peripheral pin disables
  output logic      [sgm_pkg::NUM_PWM-1:0] pwm_pin_disable,
  output logic                            sdo_pin_disable,
  output logic      [1:0]                 tx_pin_disable,
  output logic                            ref_clk_pin_disable
);

  typedef struct packed {
    logic                       en;
    logic                       oe;
    logic                       slew;
    logic                       oinv;
    logic                       swbit;
    logic                       mod_dis;
    logic [sgm_pkg::SEL_W-1:0]  mod_sel;
    logic                       h_dis;
    logic                       h_inv;
    logic                       h_sync;
    logic [sgm_pkg::SEL_W-1:0]  h_sel;
    logic                       l_dis;
    logic                       l_inv;
    logic                       l_sync;
    logic [sgm_pkg::SEL_W-1:0]  l_sel;
    sgm_pkg::sgm_phase_e        phase;
    logic                       hc_prev;
    logic                       lc_prev;
    logic                       status;
    logic                       out_pin;
    logic [sgm_pkg::NUM_PWM-1:0] pwm_dis;
    logic                       sdo_dis;
    logic [1:0]                 tx_dis;
    logic                       ref_dis;
    logic [sgm_pkg::DATA_W-1:0] rdata;
  } sgm_state_s;

  // Reset image; control comes up with only slew limiting on
  localparam sgm_state_s ST_RST = '{
    slew:  sgm_pkg::CTRL_RST[sgm_pkg::CTRL_SLEW_BIT],
    phase: sgm_pkg::PHASE_LOW,
    default: '0
  };

  sgm_state_s q;
  sgm_state_s d;

  logic [3:0] pins_sync;
  logic       mod_pin_s;
  logic       cin1_s;
  logic       cin2_s;
  logic       refclk_s;

  // Pin and reference clock inputs come from outside the clock domain
  sgm_sync2 u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in ({ref_clk_in, carrier_input_pin_two, carrier_input_pin_one,
                modulator_input_pin}),
    .sync_out (pins_sync)
  );

  assign mod_pin_s = pins_sync[0];
  assign cin1_s    = pins_sync[1];
  assign cin2_s    = pins_sync[2];
  assign refclk_s  = pins_sync[3];

  // Carrier source decode, shared by both carriers
  function automatic logic car_pick(input logic [sgm_pkg::SEL_W-1:0] sel,
                                    input logic p1, input logic p2,
                                    input logic rc,
                                    input logic [sgm_pkg::NUM_PWM-1:0] pwm);
    logic [sgm_pkg::SEL_W-1:0] idx;
    logic                      val;
    idx = sel - sgm_pkg::CAR_PWM1;
    val = 1'b0;
    case (sel)
      sgm_pkg::CAR_GND:    val = 1'b0;
      sgm_pkg::CAR_PIN1:   val = p1;
      sgm_pkg::CAR_PIN2:   val = p2;
      sgm_pkg::CAR_REFCLK: val = rc;
      default: begin
        if (sel >= sgm_pkg::CAR_PWM1 && idx < 4'(sgm_pkg::NUM_PWM)) begin
          val = pwm[idx[2:0]];
        end
      end
    endcase
    return val; // Reserved codes mix as ground [RULE_15]
  endfunction

  // One-hot of the PWM unit a code names, zero when it names none
  function automatic logic [sgm_pkg::NUM_PWM-1:0] pwm_hit(
      input logic [sgm_pkg::SEL_W-1:0] sel,
      input logic [sgm_pkg::SEL_W-1:0] base);
    logic [sgm_pkg::NUM_PWM-1:0] hit;
    hit = '0;
    for (int i = 0; i < sgm_pkg::NUM_PWM; i++) begin
      hit[i] = (sel == 4'(int'(base) + i));
    end
    return hit;
  endfunction

  logic                      mod_now;
  logic [sgm_pkg::SEL_W-1:0] h_sel_eff;
  logic [sgm_pkg::SEL_W-1:0] l_sel_eff;
  logic                      hc;
  logic                      lc;
  logic                      hc_fall;
  logic                      lc_fall;
  logic                      mix;
  logic [sgm_pkg::DATA_W-1:0] rb;

  // Source selection; disabled module falls back to ground and software bit
  always_comb begin
    h_sel_eff = q.en ? q.h_sel : sgm_pkg::CAR_GND; // [RULE_02]
    l_sel_eff = q.en ? q.l_sel : sgm_pkg::CAR_GND; // [RULE_02]
    mod_now   = q.swbit; // [RULE_02] [RULE_16]
    if (q.en) begin
      case (q.mod_sel) // [RULE_14]
        sgm_pkg::MOD_SW:  mod_now = q.swbit; // [RULE_16]
        sgm_pkg::MOD_PIN: mod_now = mod_pin_s;
        sgm_pkg::MOD_SDO: mod_now = sdo_out;
        sgm_pkg::MOD_TX1: mod_now = tx_out[0];
        sgm_pkg::MOD_TX2: mod_now = tx_out[1];
        default: begin
          mod_now = |(pwm_hit(q.mod_sel, sgm_pkg::MOD_PWM1) & pwm_out);
        end
      endcase
    end
    hc = car_pick(h_sel_eff, cin1_s, cin2_s, refclk_s, pwm_out) ^ q.h_inv; // [RULE_09]
    lc = car_pick(l_sel_eff, cin1_s, cin2_s, refclk_s, pwm_out) ^ q.l_inv; // [RULE_10]
    hc_fall = q.hc_prev & ~hc;
    lc_fall = q.lc_prev & ~lc;
  end

  // Register readback, unimplemented bits as zero
  always_comb begin
    rb = '0;
    case (reg_addr)
      sgm_pkg::REG_CTRL: begin
        rb[sgm_pkg::CTRL_EN_BIT]    = q.en;
        rb[sgm_pkg::CTRL_OE_BIT]    = q.oe;
        rb[sgm_pkg::CTRL_SLEW_BIT]  = q.slew;
        rb[sgm_pkg::CTRL_OINV_BIT]  = q.oinv;
        rb[sgm_pkg::CTRL_STAT_BIT]  = q.status; // [RULE_19]
        rb[sgm_pkg::CTRL_SWBIT_BIT] = q.swbit;
      end
      sgm_pkg::REG_SRC: begin
        rb[sgm_pkg::SRC_DIS_BIT] = q.mod_dis;
        rb[sgm_pkg::SEL_W-1:0]   = q.mod_sel;
      end
      sgm_pkg::REG_HCAR: begin
        rb[sgm_pkg::CAR_DIS_BIT]  = q.h_dis;
        rb[sgm_pkg::CAR_INV_BIT]  = q.h_inv;
        rb[sgm_pkg::CAR_SYNC_BIT] = q.h_sync;
        rb[sgm_pkg::SEL_W-1:0]    = q.h_sel;
      end
      default: begin
        rb[sgm_pkg::CAR_DIS_BIT]  = q.l_dis;
        rb[sgm_pkg::CAR_INV_BIT]  = q.l_inv;
        rb[sgm_pkg::CAR_SYNC_BIT] = q.l_sync;
        rb[sgm_pkg::SEL_W-1:0]    = q.l_sel;
      end
    endcase
  end

  // Next state: carrier phase, mixing, pin drive, register writes
  always_comb begin
    d = q;
    // Phase follows the modulator, held back until the next fall of the synced carrier being left
    case (q.phase)
      sgm_pkg::PHASE_HIGH: begin
        if (!mod_now && (!q.h_sync || hc_fall)) begin // [RULE_06] [RULE_08]
          d.phase = sgm_pkg::PHASE_LOW;
        end
      end
      sgm_pkg::PHASE_LOW: begin
        if (mod_now && (!q.l_sync || lc_fall)) begin // [RULE_07] [RULE_08]
          d.phase = sgm_pkg::PHASE_HIGH;
        end
      end
      default: d.phase = sgm_pkg::PHASE_LOW;
    endcase
    if (!q.en) begin
      d.phase = mod_now ? sgm_pkg::PHASE_HIGH : sgm_pkg::PHASE_LOW;
    end
    d.hc_prev = hc;
    d.lc_prev = lc;
    // Mixing runs on core_clk only, so it keeps going in sleep [RULE_20]
    mix = q.en & ((d.phase == sgm_pkg::PHASE_HIGH) ? hc : lc); // [RULE_01] [RULE_04]
    d.status  = mix ^ q.oinv; // [RULE_17] [RULE_19]
    d.out_pin = q.oe & d.status; // [RULE_03] [RULE_05]
    // Pin disables only while enabled; disabled selects name no peripheral
    d.pwm_dis = '0;
    d.sdo_dis = 1'b0;
    d.tx_dis  = '0;
    d.ref_dis = 1'b0;
    if (q.en) begin
      if (q.mod_dis) begin // [RULE_13]
        d.pwm_dis   = pwm_hit(q.mod_sel, sgm_pkg::MOD_PWM1);
        d.sdo_dis   = (q.mod_sel == sgm_pkg::MOD_SDO);
        d.tx_dis[0] = (q.mod_sel == sgm_pkg::MOD_TX1);
        d.tx_dis[1] = (q.mod_sel == sgm_pkg::MOD_TX2);
      end
      if (q.h_dis) begin // [RULE_11]
        d.pwm_dis = d.pwm_dis | pwm_hit(q.h_sel, sgm_pkg::CAR_PWM1);
        d.ref_dis = d.ref_dis | (q.h_sel == sgm_pkg::CAR_REFCLK);
      end
      if (q.l_dis) begin // [RULE_12]
        d.pwm_dis = d.pwm_dis | pwm_hit(q.l_sel, sgm_pkg::CAR_PWM1);
        d.ref_dis = d.ref_dis | (q.l_sel == sgm_pkg::CAR_REFCLK);
      end
    end
    // Writes touch implemented bits only; status stays hardware-owned
    if (reg_wr) begin
      case (reg_addr) // [RULE_22]
        sgm_pkg::REG_CTRL: begin
          d.en    = reg_wdata[sgm_pkg::CTRL_EN_BIT];
          d.oe    = reg_wdata[sgm_pkg::CTRL_OE_BIT];
          d.slew  = reg_wdata[sgm_pkg::CTRL_SLEW_BIT]; // [RULE_18]
          d.oinv  = reg_wdata[sgm_pkg::CTRL_OINV_BIT];
          d.swbit = reg_wdata[sgm_pkg::CTRL_SWBIT_BIT];
        end
        sgm_pkg::REG_SRC: begin
          d.mod_dis = reg_wdata[sgm_pkg::SRC_DIS_BIT];
          d.mod_sel = reg_wdata[sgm_pkg::SEL_W-1:0];
        end
        sgm_pkg::REG_HCAR: begin
          d.h_dis  = reg_wdata[sgm_pkg::CAR_DIS_BIT];
          d.h_inv  = reg_wdata[sgm_pkg::CAR_INV_BIT];
          d.h_sync = reg_wdata[sgm_pkg::CAR_SYNC_BIT];
          d.h_sel  = reg_wdata[sgm_pkg::SEL_W-1:0];
        end
        default: begin
          d.l_dis  = reg_wdata[sgm_pkg::CAR_DIS_BIT];
          d.l_inv  = reg_wdata[sgm_pkg::CAR_INV_BIT];
          d.l_sync = reg_wdata[sgm_pkg::CAR_SYNC_BIT];
          d.l_sel  = reg_wdata[sgm_pkg::SEL_W-1:0];
        end
      endcase
    end
    // Read data stands for one cycle only, zero otherwise
    d.rdata = reg_rd ? rb : '0;
  end

  // Reset returns every register to its default and disables mixing
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= ST_RST; // [RULE_21]
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata            = q.rdata;
  assign modulated_output_pin = q.out_pin;
  assign output_slew_limit    = q.slew; // [RULE_18]
  assign pwm_pin_disable      = q.pwm_dis;
  assign sdo_pin_disable      = q.sdo_dis;
  assign tx_pin_disable       = q.tx_dis;
  assign ref_clk_pin_disable  = q.ref_dis;

  // Checks on the modulator behaviour
  a_pin_low_off: assert property (@(posedge core_clk) disable iff (srst) // [RULE_03]
    !q.oe |=> !modulated_output_pin)
    else $error("output pin high while pin output disabled");

  a_disabled_quiet: assert property (@(posedge core_clk) disable iff (srst) // [RULE_04]
    !q.en |=> (q.status == $past(q.oinv)))
    else $error("disabled modulator produced output");

  a_slew_reset: assert property (@(posedge core_clk) disable iff (srst) // [RULE_18]
    $fell(srst) |-> output_slew_limit)
    else $error("slew limit not set after reset");

  a_high_sync_hold: assert property (@(posedge core_clk) disable iff (srst) // [RULE_06]
    (q.en && q.phase == sgm_pkg::PHASE_HIGH && q.h_sync && !hc_fall)
      |=> (q.phase == sgm_pkg::PHASE_HIGH))
    else $error("left high carrier before its falling edge");

  a_low_sync_hold: assert property (@(posedge core_clk) disable iff (srst) // [RULE_07]
    (q.en && q.phase == sgm_pkg::PHASE_LOW && q.l_sync && !lc_fall)
      |=> (q.phase == sgm_pkg::PHASE_LOW))
    else $error("left low carrier before its falling edge");

  a_nosync_switch: assert property (@(posedge core_clk) disable iff (srst) // [RULE_08]
    (q.en && q.phase == sgm_pkg::PHASE_HIGH && !q.h_sync && !mod_now)
      |=> (q.phase == sgm_pkg::PHASE_LOW))
    else $error("unsynchronised carrier did not switch");

  a_read_reserved: assert property (@(posedge core_clk) disable iff (srst) // [RULE_22]
    (reg_rd && reg_addr == sgm_pkg::REG_CTRL)
      |=> (reg_rdata[sgm_pkg::CTRL_STAT_BIT-1:sgm_pkg::CTRL_SWBIT_BIT+1] == '0))
    else $error("unimplemented control bits read nonzero");

  a_src_reserved: assert property (@(posedge core_clk) disable iff (srst) // [RULE_22]
    (reg_rd && reg_addr == sgm_pkg::REG_SRC)
      |=> (reg_rdata[sgm_pkg::SRC_DIS_BIT-1:sgm_pkg::SEL_W] == '0))
    else $error("unimplemented source bits read nonzero");

  a_read_once: assert property (@(posedge core_clk) disable iff (srst) // read data clears without a strobe
    !reg_rd |=> (reg_rdata == '0))
    else $error("read data stood without a read");

  a_tx_pin_dis: assert property (@(posedge core_clk) disable iff (srst) // [RULE_13]
    (q.en && q.mod_dis && q.mod_sel == sgm_pkg::MOD_TX1) |=> tx_pin_disable[0])
    else $error("modulator source pin not disabled");

  a_status_pin: assert property (@(posedge core_clk) disable iff (srst) // [RULE_05]
    $past(q.oe) |-> (modulated_output_pin == q.status))
    else $error("enabled pin differs from modulator output");

  c_sync_wait: cover property (@(posedge core_clk) disable iff (srst)
    q.en && q.h_sync && q.phase == sgm_pkg::PHASE_HIGH && !mod_now ##1 hc_fall);
  c_fsk_switch: cover property (@(posedge core_clk) disable iff (srst)
    q.en && q.phase == sgm_pkg::PHASE_LOW ##1 q.phase == sgm_pkg::PHASE_HIGH);
  c_pin_high: cover property (@(posedge core_clk) disable iff (srst)
    modulated_output_pin);

endmodule // sgm_signal_modulator
`default_nettype wire

// file: testbench/sgm_src_model.sv
/*
  Model of the on-chip peripherals and input pins that feed the modulator.
  Assumes the bench sets the wanted source levels on src_lvl; they appear
  on the outputs one core_clk edge later, as registered peripheral outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module sgm_src_model (
  // Clock, wanted levels and the PWM pin disables from the modulator
  input  wire logic        core_clk,
  input  wire logic [11:0] src_lvl,
  input  wire logic [4:0]  pwm_pin_disable,
  // Sources seen by the modulator
  output logic             modulator_input_pin,
  output logic             carrier_input_pin_one,
  output logic             carrier_input_pin_two,
  output logic             ref_clk_in,
  output logic      [4:0]  pwm_out,
  output logic             sdo_out,
  output logic      [1:0]  tx_out,
  // Level each PWM unit puts on its own pin
  output logic      [4:0]  pwm_pin_lvl
);
  logic [11:0] lvl_q = 12'h000;

  // Registered like a real peripheral, so changes land just after an edge
  always @(posedge core_clk) begin
    lvl_q <= src_lvl;
  end

  // Bit order: pin, sdo, tx1, tx2, pwm1..5, carrier pin one, two, reference
  assign {ref_clk_in, carrier_input_pin_two, carrier_input_pin_one, pwm_out, tx_out, sdo_out,
          modulator_input_pin} = lvl_q;

  // A unit stops driving its pin while asked, its signal still reaches the mixer
  assign pwm_pin_lvl = pwm_out & ~pwm_pin_disable;
endmodule // sgm_src_model
`default_nettype wire

// file: testbench/testbench.sv
/*
  Self-checking bench for the signal modulator: register access, source and
  carrier selection, enable, polarity and carrier synchronisation.
  Assumes sgm_pkg, the design and sgm_src_model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  logic                       core_clk = 1'b0;
  logic                       srst = 1'b1;
  logic [sgm_pkg::ADDR_W-1:0] reg_addr = 2'h0;
  logic [sgm_pkg::DATA_W-1:0] reg_wdata = 8'h00;
  logic                       reg_wr = 1'b0;
  logic                       reg_rd = 1'b0;
  logic [sgm_pkg::DATA_W-1:0] reg_rdata;
  logic [11:0]                src_lvl = 12'h000;
  logic                       min_pin, cin1, cin2, refc, sdo, sdo_dis, ref_dis, out_pin, slew;
  logic [4:0]                 pwm, pwm_dis, pwm_pin_lvl;
  logic [1:0]                 tx, tx_dis;
  int                         fail_count = 0;
  int                         checks = 0;

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  sgm_src_model u_src (.core_clk(core_clk), .src_lvl(src_lvl), .pwm_pin_disable(pwm_dis),
    .modulator_input_pin(min_pin), .carrier_input_pin_one(cin1), .carrier_input_pin_two(cin2),
    .ref_clk_in(refc), .pwm_out(pwm), .sdo_out(sdo), .tx_out(tx), .pwm_pin_lvl(pwm_pin_lvl));

  sgm_signal_modulator DUT (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .modulator_input_pin(min_pin), .carrier_input_pin_one(cin1), .carrier_input_pin_two(cin2),
    .ref_clk_in(refc), .pwm_out(pwm), .sdo_out(sdo), .tx_out(tx),
    .modulated_output_pin(out_pin), .output_slew_limit(slew), .pwm_pin_disable(pwm_dis),
    .sdo_pin_disable(sdo_dis), .tx_pin_disable(tx_dis), .ref_clk_pin_disable(ref_dis));

  // Single-cycle register write
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic src(input logic [11:0] v);
    @(posedge core_clk);
    src_lvl <= v;
  endtask

  // Long enough for the two-flop pin synchronisers plus the model's register
  task automatic settle();
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [7:0] ctrl(logic en, logic oe, logic inv, logic sw);
    return {en, oe, 1'b1, inv, 3'b000, sw};
  endfunction

  task automatic chk_defaults();
    logic [7:0] d;
    rd(sgm_pkg::REG_CTRL, d); `CHK(d, 8'h20)
    rd(sgm_pkg::REG_SRC, d);  `CHK(d, 8'h00)
    rd(sgm_pkg::REG_HCAR, d); `CHK(d, 8'h00)
    rd(sgm_pkg::REG_LCAR, d); `CHK(d, 8'h00)
    `CHK({out_pin, slew}, 2'b01)
  endtask

  // Unimplemented bits read zero; a second reset restores defaults
  task automatic t_regs();
    logic [7:0] d;
    chk_defaults();
    wr(sgm_pkg::REG_SRC, 8'hFF);  rd(sgm_pkg::REG_SRC, d);  `CHK(d, 8'h8F)
    wr(sgm_pkg::REG_HCAR, 8'hFF); rd(sgm_pkg::REG_HCAR, d); `CHK(d, 8'hEF)
    wr(sgm_pkg::REG_LCAR, 8'hFF); rd(sgm_pkg::REG_LCAR, d); `CHK(d, 8'hEF)
    wr(sgm_pkg::REG_CTRL, 8'h0E); rd(sgm_pkg::REG_CTRL, d); `CHK(d, 8'h00)
    @(posedge core_clk) srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    chk_defaults();
  endtask

  // Every modulator source code, with the high carrier a constant one
  task automatic t_mod_src();
    logic [7:0] d;
    logic [11:0] v;
    for (int c = 0; c < 16; c++) begin
      wr(sgm_pkg::REG_HCAR, 8'h40); wr(sgm_pkg::REG_LCAR, 8'h00);
      wr(sgm_pkg::REG_SRC, 8'h80 | 8'(c));
      src(12'h000); wr(sgm_pkg::REG_CTRL, ctrl(1, 1, 0, c != 0)); settle();
      `CHK(out_pin, 1'b0)
      v = (c >= 10) ? 12'hFFF : (c == 0) ? 12'h000 : 12'h001 << (c - 1);
      src(v); wr(sgm_pkg::REG_CTRL, ctrl(1, 1, 0, c == 0)); settle();
      `CHK(out_pin, c <= 9)
      rd(sgm_pkg::REG_CTRL, d); `CHK(d[3], c <= 9)
      `CHK(pwm_pin_lvl, (c >= 10) ? 5'h1F : 5'h00)
      `CHK({ref_dis, pwm_dis, tx_dis, sdo_dis}, (c == 2) ? 9'h001 :
           (c >= 3 && c <= 9) ? 9'h002 << (c - 3) : 9'h000)
    end
  endtask

  // Every carrier code on one side, the other side grounded
  task automatic t_car(input logic hi);
    logic [11:0] v;
    logic [1:0] a, o;
    a = hi ? sgm_pkg::REG_HCAR : sgm_pkg::REG_LCAR;
    o = hi ? sgm_pkg::REG_LCAR : sgm_pkg::REG_HCAR;
    for (int k = 0; k < 16; k++) begin
      v = (k >= 9) ? 12'hFFF : (k == 1) ? 12'h200 : (k == 2) ? 12'h400 :
          (k == 3) ? 12'h800 : (k == 0) ? 12'h000 : 12'h001 << k;
      wr(sgm_pkg::REG_SRC, 8'h00); wr(o, 8'h00); wr(a, 8'h80 | 8'(k));
      src(v); wr(sgm_pkg::REG_CTRL, ctrl(1, 1, 0, hi)); settle();
      `CHK(out_pin, k >= 1 && k <= 8)
      `CHK({ref_dis, pwm_dis, tx_dis, sdo_dis}, (k == 3) ? 9'h100 :
           (k >= 4 && k <= 8) ? 9'h008 << (k - 4) : 9'h000)
      `CHK(pwm_pin_lvl, (k >= 9) ? 5'h1F : 5'h00)
      if (k <= 8) begin
        src(12'h000); wr(a, 8'h40 | 8'(k)); settle();
        `CHK(out_pin, 1'b1)
      end
    end
  endtask

  // Enable, pin enable, output polarity and slew control
  task automatic t_en();
    logic [7:0] d;
    wr(sgm_pkg::REG_SRC, 8'h01); wr(sgm_pkg::REG_HCAR, 8'h01); wr(sgm_pkg::REG_LCAR, 8'h00);
    src(12'h201);
    wr(sgm_pkg::REG_CTRL, ctrl(1, 1, 0, 0)); settle(); `CHK(out_pin, 1'b1)
    wr(sgm_pkg::REG_CTRL, ctrl(1, 0, 0, 0)); settle(); `CHK(out_pin, 1'b0)
    rd(sgm_pkg::REG_CTRL, d); `CHK(d, 8'hA8)
    wr(sgm_pkg::REG_CTRL, ctrl(1, 1, 1, 0)); settle(); `CHK(out_pin, 1'b0)
    wr(sgm_pkg::REG_CTRL, ctrl(0, 1, 0, 1)); settle(); `CHK(out_pin, 1'b0)
    rd(sgm_pkg::REG_SRC, d);  `CHK(d, 8'h01)
    rd(sgm_pkg::REG_HCAR, d); `CHK(d, 8'h01)
    wr(sgm_pkg::REG_CTRL, 8'h40); settle();
    `CHK({slew, out_pin}, 2'b00)
  endtask

  // Carrier switch on a modulator edge, with and without synchronisation
  task automatic t_sync(input logic hl, input logic sy);
    logic [11:0] m, c;
    m = hl ? 12'h000 : 12'h004;
    c = hl ? 12'h010 : 12'h020;
    wr(sgm_pkg::REG_SRC, 8'h03); wr(sgm_pkg::REG_HCAR, 8'h04); wr(sgm_pkg::REG_LCAR, 8'h05);
    src((12'h004 ^ m) | c); wr(sgm_pkg::REG_CTRL, ctrl(1, 1, 0, 0)); settle();
    wr(sgm_pkg::REG_HCAR, {2'b00, sy & hl, 5'h04});
    wr(sgm_pkg::REG_LCAR, {2'b00, sy & ~hl, 5'h05}); settle();
    `CHK(out_pin, 1'b1)
    src(m | c); settle(); `CHK(out_pin, sy)
    src(m); settle(); `CHK(out_pin, 1'b0)
    src(m | c); settle(); `CHK(out_pin, 1'b0)
  endtask

  task automatic conclude();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence; reset is held for 16 edges, then the tasks run in turn
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    t_regs();
    t_en();
    t_mod_src();
    t_car(1'b1);
    t_car(1'b0);
    for (int i = 0; i < 4; i++) begin
      t_sync(i[1], i[0]);
    end
    conclude();
  end

  // Watchdog well beyond the fewer than 1500 cycles the tests need
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
